// ---- inc/redriver_cfg_pkg.sv ----
// Constants for the redriver general configuration register bank.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package redriver_cfg_pkg;
  localparam logic [7:0] LANE_CFG_OFS    = 8'h0A;
  localparam logic [7:0] CHAN_REV_OFS    = 8'h0B;
  localparam logic [7:0] GAIN_ROLE_OFS   = 8'h0C;
  localparam logic [7:0] LANE_CFG_RST    = 8'h01;
  localparam logic [7:0] CHAN_REV_RST    = 8'h00;
  localparam logic [7:0] GAIN_ROLE_RST   = 8'h00;
  localparam logic [7:0] LANE_CFG_MASK   = 8'h7F;
  localparam logic [7:0] CHAN_REV_MASK   = 8'h0F;
  localparam logic [7:0] GAIN_ROLE_MASK  = 8'h7F;
  localparam int         SEL_LSB         = 0;
  localparam int         FLIP_BIT        = 2;
  localparam int         HP_FORCE_BIT    = 3;
  localparam int         EQ_SRC_BIT      = 4;
  localparam int         GLOBAL_REV_BIT  = 5;
  localparam int         CABLE_BIT       = 6;
  localparam int         ROLE_LSB        = 0;
  localparam int         GAIN_LSB        = 2;
  localparam int         GAIN_SRC_BIT    = 6;
  localparam int         NUM_CHAN        = 4;
  localparam logic [1:0] SEL_OFF         = 2'h0;
  localparam logic [1:0] SEL_USB         = 2'h1;
  localparam logic [1:0] SEL_DP4         = 2'h2;
  localparam logic [1:0] SEL_DP2_USB     = 2'h3;
  localparam logic [2:0] LANES_0         = 3'h0;
  localparam logic [2:0] LANES_2         = 3'h2;
  localparam logic [2:0] LANES_4         = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [6:0] SLAVE_ADDR_DEF  = 7'h44;  // Arbitrary default bus address.
endpackage

// ---- inc/chan_ctrl_if.sv ----
// Carrier between the register bank and one channel steering slice.
// Assumes the bank drives the request side and the slice the result side.
`timescale 1ns/1ps
`default_nettype none
interface chan_ctrl_if;
  logic       rev;       // Channel reversed.
  logic       use_reg;   // Equalization taken from registers.
  logic [3:0] strap_eq;  // Sampled equalization strap code.
  logic [3:0] reg_eq_a;  // Register equalization, port A.
  logic [3:0] reg_eq_b;  // Register equalization, port B.
  logic       out_rev;   // Registered direction.
  logic [3:0] out_eq_a;  // Registered equalization, port A.
  logic [3:0] out_eq_b;  // Registered equalization, port B.
  modport bank  (output rev, use_reg, strap_eq, reg_eq_a, reg_eq_b,
                 input out_rev, out_eq_a, out_eq_b);
  modport slice (input rev, use_reg, strap_eq, reg_eq_a, reg_eq_b,
                 output out_rev, out_eq_a, out_eq_b);
endinterface
`default_nettype wire

// ---- src/chan_steer.sv ----
// One channel slice: picks its equalization source and applies reversal.
// Assumes request signals come from the register bank on the same clock.
`timescale 1ns/1ps
`default_nettype none
module chan_steer (
  input  wire logic  i_clk, // System clock.
  input  wire logic  i_rst, // Synchronous reset, active high.
  chan_ctrl_if.slice c      // Channel request and result.
);
  import redriver_cfg_pkg::*;

  logic [3:0] eq_a;
  logic [3:0] eq_b;

  assign eq_a = c.use_reg ? c.reg_eq_a : c.strap_eq;
  assign eq_b = c.use_reg ? c.reg_eq_b : c.strap_eq;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      c.out_rev  <= 1'b0;
      c.out_eq_a <= 4'h0;
      c.out_eq_b <= 4'h0;
    end else begin
      c.out_rev  <= c.rev;
      c.out_eq_a <= c.rev ? eq_b : eq_a;
      c.out_eq_b <= c.rev ? eq_a : eq_b;
    end
  end

  chk_eq_source: assert property (@(posedge i_clk) disable iff (i_rst)
    (!c.use_reg && !c.rev) |=> (c.out_eq_a == $past(c.strap_eq)))
    else $error("strap equalization not applied");
  chk_chan_swap: assert property (@(posedge i_clk) disable iff (i_rst)
    (c.use_reg && c.rev) |=> (c.out_eq_a == $past(c.reg_eq_b) && c.out_rev))
    else $error("reversed channel settings not swapped");
endmodule
`default_nettype wire

// ---- src/redriver_cfg_regs.sv ----
// General configuration register bank of a four-channel redriver, on I2C.
// Assumes SCL is far slower than i_clk and that SDA is a wired-AND bus.
// Behaviour
// - select 00 disables all lanes.
// - lane select resets to USB only.
// - 10 gives four display, 11 two plus USB.
// - cable bit enables snoop and hotplug control.
// - cable with hotplug high, snoop off and a USB link gives two lanes.
// - cable with hotplug high and no USB link gives four lanes.
// - global bit reverses every channel.
// - equalization from straps or registers.
// - hotplug force bit holds status high.
// - flip bit drives lane orientation mapping.
// - per-channel bit swaps direction and equalization.
// - reverse bit index equals channel index.
// - swing/gain source from pins or register.
// - swing/gain reads pins unless overridden.
// - swing/gain packs two pin codes.
// - role field selects alternate mode.
`timescale 1ns/1ps
`default_nettype none
module redriver_cfg_regs #(
  parameter logic [6:0] SLAVE_ADDR = redriver_cfg_pkg::SLAVE_ADDR_DEF // Bus address.
) (
  input  wire logic        i_clk,          // System clock, 100 MHz.
  input  wire logic        i_rst,          // Synchronous reset, active high.
  input  wire logic        i_scl,          // I2C clock pin.
  input  wire logic        i_sda,          // I2C data pin level.
  output logic             o_sda,          // I2C data drive value, always 0.
  output logic             o_sda_oe,       // I2C data pull-low enable.
  input  wire logic        i_hotplug,      // Hotplug input pin.
  input  wire logic        i_orient,       // Orientation pin.
  input  wire logic [3:0]  i_eq_strap,     // Equalization strap code.
  input  wire logic [1:0]  i_cfg1,         // Gain pin 1 code.
  input  wire logic [1:0]  i_cfg0,         // Gain pin 0 code.
  input  wire logic        i_snoop_off,    // Auxiliary snooping disabled.
  input  wire logic        i_usb_ss,       // USB SuperSpeed link present.
  input  wire logic [2:0]  i_snoop_lanes,  // Snooped display lane count.
  input  wire logic [15:0] i_eq_reg_a,     // Register equalization, port A.
  input  wire logic [15:0] i_eq_reg_b,     // Register equalization, port B.
  output logic             o_usb_en,       // USB lanes enabled.
  output logic [2:0]       o_dp_lanes,     // Display lanes enabled.
  output logic             o_hotplug,      // Internal hotplug status.
  output logic             o_flip,         // Lane orientation flipped.
  output logic [3:0]       o_swing_gain,   // Swing and DC gain in use.
  output logic [1:0]       o_alt_role,     // Alternate-mode role.
  output logic [3:0]       o_chan_rev,     // Per-channel reversed.
  output logic [15:0]      o_chan_eq_a,    // Per-channel equalization, port A.
  output logic [15:0]      o_chan_eq_b     // Per-channel equalization, port B.
);
  import redriver_cfg_pkg::*;

  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_SUB, ST_WR, ST_RD, ST_RACK} i2c_st_t;

  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  i2c_st_t     st_r;
  i2c_st_t     next_st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  ptr_r;
  logic        wr_en;
  logic [7:0]  rdata;
  logic [7:0]  lane_cfg_r;
  logic [7:0]  chan_rev_r;
  logic [7:0]  gain_role_r;
  logic [3:0]  pin_gain;
  logic [3:0]  gain_view;
  logic        hp_status;
  logic [1:0]  sel;
  logic        cable;

  // Pins are asynchronous; stage one feeds stage two only.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_r <= 12'hFFF;
      pin_s2_r <= 12'hFFF;
    end else begin
      pin_s1_r <= {i_scl, i_sda, i_hotplug, i_orient, i_eq_strap, i_cfg1, i_cfg0};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign scl_s = pin_s2_r[11];
  assign sda_s = pin_s2_r[10];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign o_sda    = 1'b0;

  // pin codes packed high then low.
  assign pin_gain  = {pin_s2_r[3:2], pin_s2_r[1:0]};
  assign gain_view = gain_role_r[GAIN_SRC_BIT] ? gain_role_r[GAIN_LSB +: 4] : pin_gain;

  always_comb begin
    case (ptr_r)
      LANE_CFG_OFS:  rdata = lane_cfg_r & LANE_CFG_MASK;
      CHAN_REV_OFS:  rdata = chan_rev_r & CHAN_REV_MASK;
      GAIN_ROLE_OFS: rdata = {1'b0, gain_role_r[GAIN_SRC_BIT], gain_view,
                              gain_role_r[ROLE_LSB +: 2]};
      default:       rdata = 8'h00;
    endcase
  end

  // write byte taken after eighth data bit.
  assign wr_en = scl_fall && (st_r == ST_WR) && (cnt_r == BITS_PER_BYTE);

  // Byte-level I2C slave; every byte addressed to us is acknowledged.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r      <= ST_IDLE;
      next_st_r <= ST_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      ptr_r     <= 8'h00;
      o_sda_oe  <= 1'b0;
    end else if (start_c) begin
      st_r     <= ST_ADDR;
      cnt_r    <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_c) begin
      st_r     <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            o_sda_oe <= 1'b1;
            st_r     <= ST_ACK;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:1] != SLAVE_ADDR) begin
                o_sda_oe <= 1'b0;
                st_r     <= ST_IDLE;
              end
              next_st_r <= sh_r[0] ? ST_RD : ST_SUB;
            end else if (st_r == ST_SUB) begin
              ptr_r     <= sh_r;
              next_st_r <= ST_WR;
            end else begin
              ptr_r     <= ptr_r + 8'h01;
              next_st_r <= ST_WR;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            st_r  <= next_st_r;
            if (next_st_r == ST_RD) begin
              sh_r     <= rdata;
              ptr_r    <= ptr_r + 8'h01;
              o_sda_oe <= !rdata[7];
            end else begin
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              o_sda_oe <= 1'b0;
              st_r     <= ST_RACK;
            end else begin
              o_sda_oe <= !sh_r[7];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            st_r <= ST_IDLE;
          end else if (scl_fall) begin
            sh_r     <= rdata;
            ptr_r    <= ptr_r + 8'h01;
            cnt_r    <= 4'h0;
            o_sda_oe <= !rdata[7];
            st_r     <= ST_RD;
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // lane configuration resets to USB only.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lane_cfg_r <= LANE_CFG_RST;
    end else if (wr_en && ptr_r == LANE_CFG_OFS) begin
      lane_cfg_r <= sh_r & LANE_CFG_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan_rev_r <= CHAN_REV_RST;
    end else if (wr_en && ptr_r == CHAN_REV_OFS) begin
      chan_rev_r <= sh_r & CHAN_REV_MASK;
    end
  end

  // gain field writable only under override.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gain_role_r <= GAIN_ROLE_RST;
    end else if (wr_en && ptr_r == GAIN_ROLE_OFS) begin
      gain_role_r[GAIN_SRC_BIT]     <= sh_r[GAIN_SRC_BIT];
      gain_role_r[ROLE_LSB +: 2]    <= sh_r[ROLE_LSB +: 2];
      if (sh_r[GAIN_SRC_BIT]) begin
        gain_role_r[GAIN_LSB +: 4] <= sh_r[GAIN_LSB +: 4];
      end
    end
  end

  assign sel   = lane_cfg_r[SEL_LSB +: 2];
  assign cable = lane_cfg_r[CABLE_BIT];
  assign hp_status = lane_cfg_r[HP_FORCE_BIT] | pin_s2_r[9];

  // select picks display and USB lanes.
  // cable mode uses snoop and hotplug.
  // two lanes when hotplug is high, snoop is off and a USB link is present.
  // four lanes with hotplug high and no USB link.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_usb_en   <= 1'b0;
      o_dp_lanes <= LANES_0;
    end else if (cable) begin
      o_usb_en <= i_usb_ss;
      if (!hp_status) begin
        o_dp_lanes <= LANES_0;
      end else if (!i_usb_ss) begin
        o_dp_lanes <= LANES_4;
      end else if (i_snoop_off || i_snoop_lanes > LANES_2) begin
        o_dp_lanes <= LANES_2;
      end else begin
        o_dp_lanes <= i_snoop_lanes;
      end
    end else begin
      o_usb_en   <= (sel == SEL_USB) || (sel == SEL_DP2_USB);
      o_dp_lanes <= (sel == SEL_DP4) ? LANES_4 :
                    (sel == SEL_DP2_USB) ? LANES_2 : LANES_0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hotplug    <= 1'b0;
      o_flip       <= 1'b0;
      o_swing_gain <= 4'h0;
      o_alt_role   <= 2'h0;
    end else begin
      o_hotplug    <= hp_status;
      o_flip       <= lane_cfg_r[FLIP_BIT] | pin_s2_r[8];
      o_swing_gain <= gain_view;
      o_alt_role   <= gain_role_r[ROLE_LSB +: 2];
    end
  end

  chan_ctrl_if ch_if [NUM_CHAN] ();

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    assign ch_if[g].rev      = lane_cfg_r[GLOBAL_REV_BIT] | chan_rev_r[g];
    assign ch_if[g].use_reg  = lane_cfg_r[EQ_SRC_BIT];
    assign ch_if[g].strap_eq = pin_s2_r[7:4];
    assign ch_if[g].reg_eq_a = i_eq_reg_a[4*g +: 4];
    assign ch_if[g].reg_eq_b = i_eq_reg_b[4*g +: 4];
    assign o_chan_rev[g]         = ch_if[g].out_rev;
    assign o_chan_eq_a[4*g +: 4] = ch_if[g].out_eq_a;
    assign o_chan_eq_b[4*g +: 4] = ch_if[g].out_eq_b;
    chan_steer u_chan (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .c     (ch_if[g])
    );
  end

  chk_lane_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel == SEL_OFF && !cable) |=> (!o_usb_en && o_dp_lanes == LANES_0))
    else $error("disabled select left a lane on");
  chk_lane_reset: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> (lane_cfg_r == LANE_CFG_RST && !o_usb_en ##1 o_usb_en))
    else $error("lane select reset value wrong");
  chk_dp_four: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel == SEL_DP4 && !cable) |=> (o_dp_lanes == LANES_4 && !o_usb_en))
    else $error("four display lanes not enabled");
  chk_cable_two: assert property (@(posedge i_clk) disable iff (i_rst)
    (cable && hp_status && i_snoop_off && i_usb_ss) |=> (o_dp_lanes == LANES_2))
    else $error("cable mode did not give two lanes");
  chk_cable_four: assert property (@(posedge i_clk) disable iff (i_rst)
    (cable && hp_status && !i_usb_ss) |=> (o_dp_lanes == LANES_4 && !o_usb_en))
    else $error("cable mode did not give four lanes");
  chk_global_rev: assert property (@(posedge i_clk) disable iff (i_rst)
    lane_cfg_r[GLOBAL_REV_BIT] |=> (o_chan_rev == 4'hF))
    else $error("global reverse missed a channel");
  chk_hp_force: assert property (@(posedge i_clk) disable iff (i_rst)
    lane_cfg_r[HP_FORCE_BIT] |=> o_hotplug)
    else $error("forced hotplug not high");
  chk_gain_view: assert property (@(posedge i_clk) disable iff (i_rst)
    (!gain_role_r[GAIN_SRC_BIT] && ptr_r == GAIN_ROLE_OFS) |-> (rdata[5:2] == pin_gain))
    else $error("gain readback not from pins");
  chk_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (lane_cfg_r[7] == 1'b0 && chan_rev_r[7:4] == 4'h0 && gain_role_r[7] == 1'b0))
    else $error("reserved bit stored a one");
endmodule
`default_nettype wire

// ---- tb/i2c_host_model.sv ----
// I2C host model that writes and reads the redriver registers.
// Assumes the bench resolves a pulled-up SDA wire from both enables.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic i_clk,    // System clock, 100 MHz.
  input  wire logic i_sda,    // Resolved SDA level.
  output logic      o_scl,    // SCL level driven by the host.
  output logic      o_sda_oe  // High pulls SDA low.
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Each SCL phase lasts 10 clocks, above the 8 that the slave needs.
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    o_sda_oe <= ~b;
    tick(6);
    o_scl <= 1'b1;
    tick(5);
    r = i_sda;
    tick(5);
    o_scl <= 1'b0;
  endtask
  // Also serves as a repeated start: SDA is released while SCL is low.
  task automatic start();
    tick(4);
    o_sda_oe <= 1'b0;
    tick(6);
    o_scl <= 1'b1;
    tick(10);
    o_sda_oe <= 1'b1;
    tick(10);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    tick(4);
    o_sda_oe <= 1'b1;
    tick(6);
    o_scl <= 1'b1;
    tick(10);
    o_sda_oe <= 1'b0;
    tick(10);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
                           output logic ok);
    logic k0, k1, k2;
    start();
    send_byte({a, 1'b0}, k0);
    send_byte(sub, k1);
    send_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d,
                          output logic ok);
    logic k0, k1, k2;
    start();
    send_byte({a, 1'b0}, k0);
    send_byte(sub, k1);
    start();
    send_byte({a, 1'b1}, k2);
    recv_byte(1'b1, d);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

// ---- tb/redriver_general_config_regs_bench.sv ----
// Self-checking bench for the redriver general configuration registers.
// Assumes the design package and the I2C host model of the bench folder.
`timescale 1ns/1ps
`default_nettype none
module redriver_general_config_regs_bench;
  import redriver_cfg_pkg::*;
  localparam logic [6:0] ADDR = 7'h44;
  logic        i_clk, i_rst, scl, sda, host_oe, o_sda, o_sda_oe, ack_seen;
  logic        hotplug, orient, snoop_off, usb_ss, o_usb_en, o_hotplug, o_flip;
  logic [1:0]  cfg1, cfg0, o_alt_role;
  logic [2:0]  snoop_lanes, o_dp_lanes;
  logic [3:0]  strap, o_swing_gain, o_chan_rev;
  logic [15:0] eq_a, eq_b, o_chan_eq_a, o_chan_eq_b;
  logic [7:0]  lane_s, rev_s, gain_s, d;
  int          failures, n_compared;
  // The wire is pulled up; whoever enables pulls it low.
  assign sda = (o_sda_oe ? o_sda : 1'b1) & ~host_oe;
  i2c_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  redriver_cfg_regs #(.SLAVE_ADDR(ADDR)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_hotplug(hotplug), .i_orient(orient), .i_eq_strap(strap),
    .i_cfg1(cfg1), .i_cfg0(cfg0), .i_snoop_off(snoop_off), .i_usb_ss(usb_ss),
    .i_snoop_lanes(snoop_lanes), .i_eq_reg_a(eq_a), .i_eq_reg_b(eq_b),
    .o_usb_en(o_usb_en), .o_dp_lanes(o_dp_lanes), .o_hotplug(o_hotplug), .o_flip(o_flip),
    .o_swing_gain(o_swing_gain), .o_alt_role(o_alt_role), .o_chan_rev(o_chan_rev),
    .o_chan_eq_a(o_chan_eq_a), .o_chan_eq_b(o_chan_eq_b));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_out(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [3:0] exp_link();
    if (!lane_s[CABLE_BIT]) begin
      case (lane_s[1:0])
        SEL_OFF: return {1'b0, LANES_0};
        SEL_USB: return {1'b1, LANES_0};
        SEL_DP4: return {1'b0, LANES_4};
        default: return {1'b1, LANES_2};
      endcase
    end
    if (!(lane_s[HP_FORCE_BIT] | hotplug)) return {usb_ss, LANES_0};
    if (!usb_ss) return {1'b0, LANES_4};
    if (snoop_off) return {1'b1, LANES_2};
    return {1'b1, (snoop_lanes > LANES_2) ? LANES_2 : snoop_lanes};
  endfunction
  function automatic logic [15:0] exp_eq(input logic side_b);
    logic [15:0] r;
    logic [3:0]  rv;
    rv = rev_s[3:0] | {4{lane_s[GLOBAL_REV_BIT]}};
    for (int n = 0; n < NUM_CHAN; n++) begin
      if (rv[n] ^ side_b) r[4*n+:4] = lane_s[EQ_SRC_BIT] ? eq_b[4*n+:4] : strap;
      else r[4*n+:4] = lane_s[EQ_SRC_BIT] ? eq_a[4*n+:4] : strap;
    end
    return r;
  endfunction
  function automatic logic [7:0] exp_gain_rd();
    return {1'b0, gain_s[6], (gain_s[6] ? gain_s[5:2] : {cfg1, cfg0}), gain_s[1:0]};
  endfunction
  task automatic check_ports();
    logic [3:0] lk;
    lk = exp_link();
    check_out("usb_en", 16'(lk[3]), 16'(o_usb_en));
    check_out("dp_lanes", 16'(lk[2:0]), 16'(o_dp_lanes));
    check_out("hotplug", 16'(lane_s[3] | hotplug), 16'(o_hotplug));
    check_out("flip", 16'(lane_s[2] | orient), 16'(o_flip));
    check_out("swing", 16'(4'(exp_gain_rd() >> 2)), 16'(o_swing_gain));
    check_out("role", 16'(gain_s[1:0]), 16'(o_alt_role));
    check_out("chan_rev", 16'(rev_s[3:0] | {4{lane_s[5]}}), 16'(o_chan_rev));
    check_out("eq_a", exp_eq(1'b0), o_chan_eq_a);
    check_out("eq_b", exp_eq(1'b1), o_chan_eq_b);
  endtask
  task automatic rand_pins();
    @(posedge i_clk);
    hotplug     <= 1'($urandom);
    orient      <= 1'($urandom);
    snoop_off   <= 1'($urandom);
    usb_ss      <= 1'($urandom);
    cfg1        <= 2'($urandom);
    cfg0        <= 2'($urandom);
    snoop_lanes <= 3'($urandom);
    strap       <= 4'($urandom);
    eq_a        <= 16'($urandom);
    eq_b        <= 16'($urandom);
    // Pins pass two sync stages and an output register.
    repeat (6) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] v);
    host.write_reg(ADDR, sub, v, ack_seen);
    check_out("write ack", 16'h0001, 16'(ack_seen));
    case (sub)
      LANE_CFG_OFS: lane_s = v & LANE_CFG_MASK;
      CHAN_REV_OFS: rev_s = v & CHAN_REV_MASK;
      GAIN_ROLE_OFS: gain_s = v[6] ? (v & GAIN_ROLE_MASK) : {2'h0, gain_s[5:2], v[1:0]};
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] e, input string nm);
    host.read_reg(ADDR, sub, d, ack_seen);
    check_out("read ack", 16'h0001, 16'(ack_seen));
    check_reg(nm, e, d);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge i_clk);
    failures++;
    $display("wrong value watchdog expected finish seen timeout");
    end_of_test();
  end
  initial begin
    void'($urandom(32'h602D1F06));
    {i_rst, hotplug, orient, snoop_off, usb_ss, cfg1, cfg0} = 9'h100;
    {snoop_lanes, strap, eq_a, eq_b} = '0;
    {lane_s, rev_s, gain_s} = {LANE_CFG_RST, CHAN_REV_RST, GAIN_ROLE_RST};
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rand_pins();
    check_ports();
    rd(LANE_CFG_OFS, LANE_CFG_RST, "lane reset");
    rd(CHAN_REV_OFS, CHAN_REV_RST, "reverse reset");
    rd(GAIN_ROLE_OFS, exp_gain_rd(), "gain reset");
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(LANE_CFG_OFS, {1'($urandom), 1'b0, 4'($urandom), 2'(s)});
      rand_pins();
      check_ports();
      rd(LANE_CFG_OFS, lane_s, "lane select");
    end
    $display("test lane select done");
    for (int j = 0; j < 2; j++) begin
      wr(LANE_CFG_OFS, {2'b01, 2'($urandom), 1'(j), 3'($urandom)});
      repeat (8) begin
        rand_pins();
        check_ports();
      end
    end
    $display("test cable done");
    for (int i = 0; i < 6; i++) begin
      wr(CHAN_REV_OFS, (i < 2) ? (i ? 8'h01 : 8'hFC) : 8'($urandom));
      wr(LANE_CFG_OFS, 8'($urandom));
      rand_pins();
      check_ports();
      rd(CHAN_REV_OFS, rev_s, "reverse");
    end
    $display("test reverse done");
    for (int r = 0; r < 4; r++) begin
      wr(GAIN_ROLE_OFS, {1'($urandom), 1'(r), 4'($urandom), 2'(r)});
      rand_pins();
      check_ports();
      rd(GAIN_ROLE_OFS, exp_gain_rd(), "gain role");
    end
    $display("test gain role done");
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'h00, "unmapped");
    host.write_reg(ADDR ^ 7'h01, LANE_CFG_OFS, 8'h02, ack_seen);
    check_out("foreign ack", 16'h0000, 16'(ack_seen));
    rd(LANE_CFG_OFS, lane_s, "lane kept");
    check_ports();
    $display("test refusals done");
    end_of_test();
  end
endmodule
`default_nettype wire
